// ---- logic/servo_alarm_manager.sv ----
// Alarm and warning manager of the servo amplifier: latches the first alarm,
// shows its code, drops fault-ok, and clears under per-alarm permissions.
// Assumes fault and warning detectors and reset commands synchronous to clk_in;
// the asynchronous reset stands for the power off-then-on cycle.
//
// Functional notes
// - Any alarm drops the fault-ok output.
// - Display the code of the fault.
// - Hold alarm while cause persists.
// - Clear by power cycle, error or CPU reset.
// - Thermal alarms use fixed codes 45, 46, 47.
// - Warnings use separate codes, 9- or E-prefixed.
// - Lock out clears of 30, 50, 51.
// - Lockout length derived from load history.
// - Receive error 1 may refuse error reset.
// - USB timeout and USB error distinct codes.
`timescale 1ns/10ps
module servo_alarm_manager #(
    parameter int unsigned TICK_CYCLES = alarm_pkg::PROT_TICK_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [alarm_pkg::NUM_ALARMS-1:0] fault_vec_in,
    input wire logic [alarm_pkg::NUM_WARNS-1:0] warn_vec_in,
    input wire logic error_reset_cmd_in,
    input wire logic cpu_reset_cmd_in,
    input wire logic servo_on_req_in,
    input wire logic [alarm_pkg::LOAD_W-1:0] load_in,
    output logic fault_ok_output_out,
    output logic [alarm_pkg::CODE_W-1:0] display_code_out,
    output logic alarm_active_out,
    output logic warn_active_out,
    output logic servo_on_out,
    output logic clear_reject_out,
    output logic lockout_out,
    output logic [alarm_pkg::SEC_W-1:0] lockout_remain_out
);
    import alarm_pkg::*;

    prot_if prot (); // Link to the protection timer.

    logic alarm_reg, alarm_next; // An alarm is latched.
    logic [IDX_W-1:0] idx_reg, idx_next; // Source index of the latched alarm.
    logic [CODE_W-1:0] disp_reg, disp_next; // Code on the status display.
    logic fault_ok_reg, fault_ok_next; // High while no alarm stands.
    logic warn_reg, warn_next; // Some warning is present.
    logic servo_reg, servo_next; // Servo-on granted.
    logic reject_reg, reject_next; // Clear request refused, one-cycle pulse.
    logic start_next; // Start pulse toward the timer.
    logic [IDX_W-1:0] first_idx; // Lowest-index active fault.
    logic [WIDX_W-1:0] first_widx; // Lowest-index active warning.
    logic clear_req; // An error or CPU reset command arrives.
    logic clear_ok; // The command is permitted for the latched alarm.
    logic cause_gone; // The latched alarm's condition has ended.

    // Timer instance; it keeps its own load history.
    protection_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .load_in(load_in),
        .prot(prot)
    );

    // Priority encoders: the lowest index wins when several rise together.
    always_comb begin
        first_idx = '0;
        first_widx = '0;
        for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
            if (fault_vec_in[i]) begin
                first_idx = IDX_W'(i);
            end
        end
        for (int j = NUM_WARNS - 1; j >= 0; j--) begin
            if (warn_vec_in[j]) begin
                first_widx = WIDX_W'(j);
            end
        end
    end

    // Latch, clear and display decisions.
    always_comb begin
        alarm_next = alarm_reg;
        idx_next = idx_reg;
        reject_next = 1'b0;
        start_next = 1'b0;
        clear_req = error_reset_cmd_in || cpu_reset_cmd_in;
        // Each command is checked against its own permission column.
        clear_ok = (error_reset_cmd_in && ERR_RST_OK[idx_reg]) ||
                   (cpu_reset_cmd_in && CPU_RST_OK[idx_reg]);
        // A receive error whose link fault persists stays latched here.
        cause_gone = !fault_vec_in[idx_reg];
        if (alarm_reg) begin
            // Later faults do not replace the latched one.
            if (clear_req) begin
                if (clear_ok && cause_gone && !(PROT_MASK[idx_reg] && prot.busy)) begin
                    alarm_next = 1'b0;
                end else begin
                    // Refused: no permission, cause present, or lockout running.
                    reject_next = 1'b1;
                end
            end
        end else if (|fault_vec_in) begin
            alarm_next = 1'b1;
            idx_next = first_idx;
            start_next = PROT_MASK[first_idx];
        end
        // Alarm codes take precedence; warnings show only without an alarm.
        if (alarm_next) begin
            disp_next = ALARM_CODE[idx_next];
        end else if (|warn_vec_in) begin
            disp_next = WARN_CODE[first_widx];
        end else begin
            disp_next = CODE_NONE;
        end
        warn_next = |warn_vec_in;
        // Fault-ok falls on a raw fault too, not only on the latch.
        fault_ok_next = !alarm_next && !(|fault_vec_in);
        servo_next = servo_on_req_in && !alarm_next && !(|fault_vec_in);
    end

    // Registers; a low clock enable freezes all of them.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            alarm_reg <= 1'b0;
            idx_reg <= '0;
            disp_reg <= CODE_NONE;
            fault_ok_reg <= 1'b0;
            warn_reg <= 1'b0;
            servo_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else if (ce_in) begin
            alarm_reg <= alarm_next;
            idx_reg <= idx_next;
            disp_reg <= disp_next;
            fault_ok_reg <= fault_ok_next;
            warn_reg <= warn_next;
            servo_reg <= servo_next;
            reject_reg <= reject_next;
        end
    end

    // The start pulse is combinational; the timer registers it on the same edge.
    assign prot.start = start_next && ce_in;

    // Outputs come straight from registers here or in the timer.
    assign fault_ok_output_out = fault_ok_reg;
    assign display_code_out = disp_reg;
    assign alarm_active_out = alarm_reg;
    assign warn_active_out = warn_reg;
    assign servo_on_out = servo_reg;
    assign clear_reject_out = reject_reg;
    assign lockout_out = prot.busy;
    assign lockout_remain_out = prot.remain;

    // A fault present at an enabled edge drops fault-ok at that edge.
    property p_fault_drops_ok;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && |fault_vec_in) |=> !fault_ok_output_out;
    endproperty
    a_fault_drops_ok: assert property (p_fault_drops_ok) else $error("Fault-ok stayed high.");

    // A fresh undervoltage alarm shows its code.
    property p_shows_code;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && !alarm_reg && fault_vec_in[0]) |=> (alarm_reg && display_code_out == 12'h010);
    endproperty
    a_shows_code: assert property (p_shows_code) else $error("Alarm code not displayed.");

    // While its cause stands the alarm cannot be cleared.
    property p_hold_while_cause;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && alarm_reg && fault_vec_in[idx_reg]) |=> (alarm_reg && $stable(idx_reg));
    endproperty
    a_hold_while_cause: assert property (p_hold_while_cause) else $error("Alarm cleared early.");

    // A permitted error reset with the cause gone clears at the next edge.
    property p_err_reset_clears;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && alarm_reg && error_reset_cmd_in && ERR_RST_OK[idx_reg] &&
         !fault_vec_in[idx_reg] && !prot.busy) |=> (!alarm_reg && !clear_reject_out);
    endproperty
    a_err_reset_clears: assert property (p_err_reset_clears) else $error("Reset did not clear.");

    // The main circuit overheat alarm always shows 45.
    property p_thermal_code;
        @(posedge clk_in) disable iff (!arst_n_in)
        (alarm_reg && idx_reg == IDX_MAIN_OVERHEAT) |-> (display_code_out == 12'h045);
    endproperty
    a_thermal_code: assert property (p_thermal_code) else $error("Wrong thermal code.");

    // A lone regeneration warning shows E0.
    property p_warn_code;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && !alarm_reg && !(|fault_vec_in) && first_widx == WIDX_REGEN &&
         |warn_vec_in) |=> (display_code_out == 12'h0E0 && warn_active_out);
    endproperty
    a_warn_code: assert property (p_warn_code) else $error("Wrong warning code.");

    // During the lockout a clear is refused and the alarm stays.
    property p_lockout_refuses;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && alarm_reg && PROT_MASK[idx_reg] && prot.busy && clear_req)
            |=> (alarm_reg && clear_reject_out) ##1 !clear_reject_out || clear_req;
    endproperty
    a_lockout_refuses: assert property (p_lockout_refuses) else $error("Lockout bypassed.");

    // The USB timeout is shown as 8A.
    property p_usb_code;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && !alarm_reg && fault_vec_in == (28'h0000001 << IDX_USB_TIMEOUT))
            |=> (display_code_out == 12'h08A);
    endproperty
    a_usb_code: assert property (p_usb_code) else $error("Wrong USB code.");

    // No servo-on while an alarm is latched.
    property p_servo_off;
        @(posedge clk_in) disable iff (!arst_n_in)
        alarm_active_out |-> !servo_on_out;
    endproperty
    a_servo_off: assert property (p_servo_off) else $error("Servo on during alarm.");

    // Without a clear command the latched code does not change.
    property p_first_kept;
        @(posedge clk_in) disable iff (!arst_n_in)
        (alarm_reg && !clear_req) |=> ($stable(display_code_out) && alarm_reg);
    endproperty
    a_first_kept: assert property (p_first_kept) else $error("Latched alarm replaced.");

    // A permitted CPU reset with the cause gone clears at the next edge.
    property p_cpu_clr;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && alarm_reg && cpu_reset_cmd_in && CPU_RST_OK[idx_reg] &&
         !fault_vec_in[idx_reg] && !prot.busy) |=> !alarm_reg;
    endproperty
    a_cpu_clr: assert property (p_cpu_clr) else $error("CPU reset failed.");

    // A command that the latched alarm does not permit is refused with a pulse.
    property p_no_perm;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && alarm_reg && clear_req && !clear_ok) |=> (alarm_reg && clear_reject_out);
    endproperty
    a_no_perm: assert property (p_no_perm) else $error("Unpermitted clear.");

    // Any clear while the cause still stands is refused with a pulse.
    property p_cause;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && alarm_reg && clear_req && fault_vec_in[idx_reg])
            |=> (alarm_reg && clear_reject_out);
    endproperty
    a_cause: assert property (p_cause) else $error("Clear with cause.");

    // A receive error whose link fault persists survives an error reset.
    property p_recv;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && alarm_reg && idx_reg == IDX_RECV_ERR1 && fault_vec_in[IDX_RECV_ERR1] &&
         error_reset_cmd_in) |=> (alarm_reg && clear_reject_out);
    endproperty
    a_recv: assert property (p_recv) else $error("Receive error cleared.");

    // Latching a lockout alarm starts the protection interval at the same edge.
    property p_lock_start;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && !alarm_reg && |fault_vec_in && PROT_MASK[first_idx])
            |=> (alarm_reg && lockout_out);
    endproperty
    a_lock_start: assert property (p_lock_start) else $error("No lockout.");

    // A clear while nothing is latched is ignored, so no reject pulse follows.
    property p_idle_clr;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && !alarm_reg && clear_req) |=> !clear_reject_out;
    endproperty
    a_idle_clr: assert property (p_idle_clr) else $error("Stray reject.");

    // With no alarm and no fault a held servo-on request is granted.
    property p_servo_grant;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && servo_on_req_in && !alarm_reg && !(|fault_vec_in)) |=> servo_on_out;
    endproperty
    a_servo_grant: assert property (p_servo_grant) else $error("No servo-on.");

    // The other USB error sits right after the timeout and shows 8E.
    property p_usb_err;
        @(posedge clk_in) disable iff (!arst_n_in)
        (alarm_reg && idx_reg == IDX_W'(IDX_USB_TIMEOUT + 1)) |-> (display_code_out == 12'h08E);
    endproperty
    a_usb_err: assert property (p_usb_err) else $error("Wrong USB error code.");

    // Main scenarios worth seeing.
    c_latch: cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(alarm_reg));
    c_clear: cover property (@(posedge clk_in) disable iff (!arst_n_in) $fell(alarm_reg));
    c_reject: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        clear_reject_out && prot.busy);
    c_recv: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        alarm_reg && idx_reg == IDX_RECV_ERR1 && clear_reject_out);
    c_lock_end: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        $fell(lockout_out));
endmodule

// ---- logic/alarm_pkg.sv ----
// Shared constants for the servo alarm manager and its protection timer.
// Assumes one 20 MHz system clock and a power-on reset that acts as the power cycle.
package alarm_pkg;

    // Clock period and the one-second tick used to time the protection interval.
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TICK_PERIOD_NS = 1000000000;
    localparam int unsigned PROT_TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Alarm and warning source counts, and widths of the codes and load figure.
    localparam int unsigned NUM_ALARMS = 28;
    localparam int unsigned NUM_WARNS = 13;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned WIDX_W = 4;
    localparam int unsigned CODE_W = 12;
    localparam int unsigned LOAD_W = 8;
    localparam int unsigned ACC_W = LOAD_W + 3;
    localparam int unsigned SEC_W = 12;

    // Display codes of the alarms, three hex digits, in source-index order.
    localparam logic [CODE_W-1:0] ALARM_CODE [NUM_ALARMS] = '{
        12'h010, 12'h012, 12'h013, 12'h015, 12'h016, 12'h017, 12'h019, 12'h01A,
        12'h020, 12'h024, 12'h025, 12'h030, 12'h031, 12'h032, 12'h033, 12'h034,
        12'h035, 12'h036, 12'h037, 12'h045, 12'h046, 12'h047, 12'h050, 12'h051,
        12'h052, 12'h08A, 12'h08E, 12'h888};

    // Display codes of the warnings, in source-index order.
    localparam logic [CODE_W-1:0] WARN_CODE [NUM_WARNS] = '{
        12'h092, 12'h096, 12'h09F, 12'h0E0, 12'h0E1, 12'h0E3, 12'h0E4, 12'h0E6,
        12'h0E7, 12'h0E8, 12'h0E9, 12'h0EC, 12'h0ED};

    // Per-alarm permission masks: error reset, CPU reset, thermal lockout.
    localparam logic [NUM_ALARMS-1:0] ERR_RST_OK = 28'h7DB9A01;
    localparam logic [NUM_ALARMS-1:0] CPU_RST_OK = 28'h7DBDA01;
    localparam logic [NUM_ALARMS-1:0] PROT_MASK = 28'h0C00800;

    // Source indices that are named in checks.
    localparam logic [IDX_W-1:0] IDX_UNDERVOLT = 5'h00;
    localparam logic [IDX_W-1:0] IDX_RECV_ERR1 = 5'h0F;
    localparam logic [IDX_W-1:0] IDX_MAIN_OVERHEAT = 5'h13;
    localparam logic [IDX_W-1:0] IDX_USB_TIMEOUT = 5'h19;
    localparam logic [WIDX_W-1:0] WIDX_REGEN = 4'h3;

    // Code shown when nothing is pending.
    localparam logic [CODE_W-1:0] CODE_NONE = 12'h000;

    // Protection interval: base seconds plus load average times a scale.
    localparam logic [SEC_W-1:0] PROT_MIN_S = 12'h03C;
    localparam logic [SEC_W-1:0] PROT_SCALE_S = 12'h007;
    localparam int unsigned HIST_SHIFT = 3;

endpackage

// ---- logic/prot_if.sv ----
// Link between the alarm manager and the thermal protection timer.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface prot_if;
    import alarm_pkg::*;
    logic start; // One-cycle pulse: a lockout alarm is being latched at this edge.
    logic busy; // Level: the protection interval is still running.
    logic [SEC_W-1:0] remain; // Seconds left in the interval.
    modport timer (input start, output busy, output remain);
    modport manager (output start, input busy, input remain);
endinterface

// ---- logic/protection_timer.sv ----
// Protection interval timer with its own load-history average.
// Assumes a synchronous load figure and a start pulse from the alarm manager.
`timescale 1ns/10ps
module protection_timer #(
    parameter int unsigned TICK_CYCLES = alarm_pkg::PROT_TICK_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [alarm_pkg::LOAD_W-1:0] load_in,
    prot_if.timer prot
);
    import alarm_pkg::*;

    localparam int unsigned TW = $clog2(TICK_CYCLES);

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_COUNT = 2'b10} tstate_t;

    tstate_t state_reg, state_next; // Idle or counting down.
    logic [TW-1:0] tick_reg, tick_next; // Divider toward one second.
    logic [ACC_W-1:0] acc_reg, acc_next; // Load history, eight times the average.
    logic [SEC_W-1:0] remain_reg, remain_next; // Seconds left.
    logic busy_reg, busy_next; // Registered busy flag.
    logic tick; // Last cycle of a second.
    logic [SEC_W-1:0] interval; // Interval that a start would load.

    // Next values: the average follows the load once a second, so the interval
    // reflects the recent load history up to the moment of the alarm.
    always_comb begin
        tick = (tick_reg == TW'(TICK_CYCLES - 1));
        tick_next = tick ? '0 : tick_reg + 1'b1;
        acc_next = acc_reg;
        if (tick) begin
            acc_next = acc_reg - (acc_reg >> HIST_SHIFT) + ACC_W'(load_in);
        end
        interval = PROT_MIN_S + SEC_W'(acc_reg[ACC_W-1:HIST_SHIFT]) * PROT_SCALE_S;
        state_next = state_reg;
        remain_next = remain_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (prot.start) begin
                    remain_next = interval;
                    state_next = ST_COUNT;
                end
            end
            ST_COUNT: begin
                // A count of one or less at a tick means the interval has run out.
                if (tick) begin
                    if (remain_reg <= 12'h001) begin
                        remain_next = '0;
                        state_next = ST_IDLE;
                    end else begin
                        remain_next = remain_reg - 1'b1;
                    end
                end
            end
        endcase
        busy_next = (state_next == ST_COUNT);
    end

    // Registers, frozen while the clock enable is low.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= ST_IDLE;
            tick_reg <= '0;
            acc_reg <= '0;
            remain_reg <= '0;
            busy_reg <= 1'b0;
        end else if (ce_in) begin
            state_reg <= state_next;
            tick_reg <= tick_next;
            acc_reg <= acc_next;
            remain_reg <= remain_next;
            busy_reg <= busy_next;
        end
    end

    assign prot.busy = busy_reg;
    assign prot.remain = remain_reg;

    // A start loads the computed interval and raises busy at once.
    property p_start_loads;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ce_in && prot.start && state_reg == ST_IDLE) |=> (busy_reg && remain_reg == $past(interval));
    endproperty
    a_start_loads: assert property (p_start_loads) else $error("Interval not loaded on start.");
endmodule

// ---- tb/motion_ctrl_model.sv ----
// Behavioural model of the motion controller that sends clear and servo-on requests.
// Assumes the amplifier samples the command lines on the rising edge of clk_in.
`timescale 1ns/10ps
module motion_ctrl_model #(
    parameter int unsigned COOL_CYCLES = 16
) (
    input wire logic clk_in,
    output logic error_reset_cmd_out,
    output logic cpu_reset_cmd_out,
    output logic servo_on_req_out
);
    // All requests idle until the bench asks for one.
    initial begin
        error_reset_cmd_out = 1'b0;
        cpu_reset_cmd_out = 1'b0;
        servo_on_req_out = 1'b0;
    end

    // One clear request lasts one sampled cycle; a cooled request waits first.
    // The wait is short here, since real cooling would make the run far too long.
    task automatic send_clear(input bit use_cpu, input bit cooled);
        if (cooled) begin
            repeat (COOL_CYCLES) @(posedge clk_in);
        end
        @(posedge clk_in);
        if (use_cpu) begin
            cpu_reset_cmd_out <= 1'b1;
        end else begin
            error_reset_cmd_out <= 1'b1;
        end
        @(posedge clk_in);
        cpu_reset_cmd_out <= 1'b0;
        error_reset_cmd_out <= 1'b0;
    endtask

    // The servo-on request is a level that the controller holds.
    task automatic set_servo(input bit v);
        @(posedge clk_in);
        servo_on_req_out <= v;
    endtask
endmodule

// ---- tb/servo_alarm_manager_tb.sv ----
// Self-checking bench for the servo alarm manager with random faults and loads.
// Assumes the controller model beside it and a shortened one-second tick.
`timescale 1ns/10ps
module servo_alarm_manager_tb;
    import alarm_pkg::*;
    localparam int unsigned TICKS = 4; // Cycles per protection second in simulation.
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic [NUM_ALARMS-1:0] fault_vec = '0;
    logic [NUM_WARNS-1:0] warn_vec = '0;
    logic [LOAD_W-1:0] load = '0;
    logic err_cmd, cpu_cmd, srv_req, fault_ok, alarm, warn, srv_on, reject, lock;
    logic [CODE_W-1:0] display;
    logic [SEC_W-1:0] remain;
    int fail_count = 0;
    int num_checks = 0;

    motion_ctrl_model ctrl (.clk_in(clk_in), .error_reset_cmd_out(err_cmd),
        .cpu_reset_cmd_out(cpu_cmd), .servo_on_req_out(srv_req));

    servo_alarm_manager #(.TICK_CYCLES(TICKS)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .ce_in(ce_in), .fault_vec_in(fault_vec), .warn_vec_in(warn_vec),
        .error_reset_cmd_in(err_cmd), .cpu_reset_cmd_in(cpu_cmd), .servo_on_req_in(srv_req),
        .load_in(load), .fault_ok_output_out(fault_ok), .display_code_out(display),
        .alarm_active_out(alarm), .warn_active_out(warn), .servo_on_out(srv_on),
        .clear_reject_out(reject), .lockout_out(lock), .lockout_remain_out(remain));

    // A 50 ns clock, free running.
    initial begin
        forever #25 clk_in = ~clk_in;
    end

    // Compare with case inequality so an unknown never counts as a match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Let the next edge land, then look at settled outputs.
    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask

    // Lowest set warning index decides the shown code.
    function automatic logic [CODE_W-1:0] warn_code(input logic [NUM_WARNS-1:0] w);
        for (int k = 0; k < NUM_WARNS; k++) begin
            if (w[k]) begin
                return WARN_CODE[k];
            end
        end
        return CODE_NONE;
    endfunction

    // Lockout seconds once a steady load has filled the eight-sample average.
    function automatic logic [SEC_W-1:0] lock_secs(input logic [LOAD_W-1:0] l);
        return PROT_MIN_S + SEC_W'(l) * PROT_SCALE_S;
    endfunction

    // Power off-then-on: outputs drop at once and recover after release.
    task automatic power_cycle();
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        #1;
        chk(fault_ok, 1'b0);
        chk(display, CODE_NONE);
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        tick();
        tick();
        chk(alarm, 1'b0);
    endtask

    // Latch alarm i, pile on a later fault, refuse while caused, then clear.
    task automatic one_alarm(input int i);
        int j;
        j = $urandom_range(0, NUM_ALARMS - 1);
        if (j == i) begin
            j = (i + 1) % NUM_ALARMS;
        end
        @(posedge clk_in);
        fault_vec <= NUM_ALARMS'(1) << i;
        load <= LOAD_W'($urandom);
        tick();
        chk(alarm, 1'b1);
        chk(display, ALARM_CODE[i]);
        chk(fault_ok, 1'b0);
        chk(srv_on, 1'b0);
        fault_vec <= fault_vec | (NUM_ALARMS'(1) << j);
        tick();
        chk(display, ALARM_CODE[i]);
        ctrl.send_clear(1'b0, 1'b0);
        #1;
        chk(reject, 1'b1);
        chk(alarm, 1'b1);
        @(posedge clk_in);
        fault_vec <= '0;
        ctrl.send_clear(1'b0, 1'b0);
        #1;
        chk(alarm, !ERR_RST_OK[i]);
        chk(reject, !ERR_RST_OK[i]);
        if (alarm === 1'b1) begin
            ctrl.send_clear(1'b1, 1'b0);
            #1;
            chk(alarm, !CPU_RST_OK[i]);
        end
        if (alarm === 1'b1) begin
            power_cycle();
        end
        tick();
        chk(fault_ok, 1'b1);
        chk(srv_on, 1'b1);
    endtask

    // Lockout alarms refuse both clears until the computed interval ends.
    task automatic lockout_alarm(input int i);
        int n;
        int s;
        // Seventy seconds of a steady load settle the average on that load.
        repeat (70 * TICKS) @(posedge clk_in);
        @(posedge clk_in);
        fault_vec <= NUM_ALARMS'(1) << i;
        tick();
        fault_vec <= '0;
        s = int'(lock_secs(load));
        chk(lock, 1'b1);
        chk(remain >= PROT_MIN_S, 1'b1);
        chk(remain, lock_secs(load));
        ctrl.send_clear(1'b0, 1'b0);
        #1;
        chk(reject, 1'b1);
        ctrl.send_clear(1'b1, 1'b0);
        #1;
        chk(alarm, 1'b1);
        n = 0;
        while (lock !== 1'b0 && n < 8000) begin
            tick();
            n++;
        end
        chk(n >= (s - 1) * int'(TICKS) - 3 && n <= s * int'(TICKS) - 4, 1'b1);
        ctrl.send_clear(1'b0, 1'b1);
        #1;
        chk(alarm, 1'b0);
        $display("test lockout %0d done", i);
    endtask

    // Main sequence: reset, idle, alarms, warnings, lockouts.
    initial begin
        logic [NUM_WARNS-1:0] w;
        void'($urandom(59));
        repeat (5) @(posedge clk_in);
        #1;
        chk(fault_ok, 1'b0);
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        ctrl.set_servo(1'b1);
        tick();
        tick();
        chk(fault_ok, 1'b1);
        chk(srv_on, 1'b1);
        ctrl.send_clear(1'b0, 1'b0);
        #1;
        chk(reject, 1'b0);
        @(posedge clk_in);
        ce_in <= 1'b0;
        fault_vec <= 28'h0000001;
        tick();
        tick();
        chk(alarm, 1'b0);
        fault_vec <= '0;
        ce_in <= 1'b1;
        $display("test idle done");
        for (int i = 0; i < NUM_ALARMS; i++) begin
            if (!PROT_MASK[i]) begin
                one_alarm(i);
            end
        end
        $display("test alarms done");
        for (int k = 0; k < 20; k++) begin
            w = (k < NUM_WARNS) ? NUM_WARNS'(1) << k : NUM_WARNS'($urandom) | 13'h0001;
            @(posedge clk_in);
            warn_vec <= w;
            tick();
            chk(warn, 1'b1);
            chk(display, warn_code(w));
            chk(fault_ok, 1'b1);
        end
        warn_vec <= '0;
        $display("test warnings done");
        for (int k = 0; k < NUM_ALARMS; k++) begin
            if (PROT_MASK[k]) begin
                load <= LOAD_W'($urandom);
                lockout_alarm(k);
            end
        end
        summarize();
    end

    // Hang guard sized well above the longest three lockouts.
    initial begin
        #(60000 * 50);
        fail_count++;
        summarize();
    end

    // Print the counts and the verdict, then stop.
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
endmodule
